/* File: rtl/stv_pkg.sv */
// Purpose: Shared constants and types for the supervisor trap value and
//          environment configuration block.
// Assumes: 32-bit supervisor register width, APB register access.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package stv_pkg;
   // ==========================================================
   // Register map
   localparam logic [11:0] STV_OFF_TVAL   = 12'h000;
   localparam logic [11:0] STV_OFF_ENVCFG = 12'h004;
   localparam logic [11:0] STV_OFF_STATUS = 12'h008;
   // ==========================================================
   // Environment configuration fields
   localparam int STV_BIT_FIOW = 0;
   localparam int STV_BIT_LPE  = 2;
   localparam int STV_BIT_SSE  = 3;
   localparam int STV_BIT_CZE  = 7;
   localparam int STV_BIT_CCFE = 6;
   localparam int STV_LO_CIE   = 4;
   localparam logic [31:0] STV_ENVCFG_RESET = 32'h0000_0000;
   localparam logic [31:0] STV_TVAL_RESET   = 32'h0000_0000;
   // ==========================================================
   // Software-check codes
   localparam logic [31:0] STV_SWC_NONE = 32'h0000_0000;
   localparam logic [31:0] STV_SWC_LANDING_PAD_INSTR = 32'h0000_0002;
   localparam logic [31:0] STV_SWC_SSTK = 32'h0000_0003;
   // ==========================================================
   // Trap kinds presented by the trap logic
   typedef enum logic [2:0] {
      STV_TK_OTHER = 3'h0,
      STV_TK_ADDR  = 3'h1,
      STV_TK_ILL   = 3'h2,
      STV_TK_SWC   = 3'h3
   } stv_kind_t;

   typedef struct packed {
      logic        take;    // Trap enters supervisor mode
      stv_kind_t   kind;    // Class of information
      logic [31:0] addr;    // Faulting portion address
      logic [31:0] instr;   // Raw instruction bits
      logic [5:0]  max_instruction_length;    // Instruction length in bits
      logic [1:0]  swc;     // Software-check cause
   } stv_trap_t;

   typedef struct packed {
      logic        lpActive;   // Landing-pad checks active in user
      logic        ssActive;   // Shadow stacks active in user
      logic        fenceWiden; // Widen user fences to memory
      logic        ssSwapIll;  // Swap raises illegal (user)
      logic        ssSwapVirt; // Swap raises virtual fault (v-user)
   } stv_ctl_t;

   typedef struct packed {
      logic [31:0] tval;
      logic [31:0] envcfg;
      logic [31:0] prdata;
      logic        trapSeen;
   } stv_state_t;
endpackage

/* File: rtl/stv_core.sv */
// Purpose: Supervisor trap value and environment configuration registers.
// Assumes: One clock; trap logic and APB on that clock.
// Notes:   Software reaches both registers over APB, zero wait states.
`timescale 1ns/1ps
`default_nettype none
module stv_core
   import stv_pkg::*;
#(
   parameter bit HAS_XLATE  = 1'b1,  // Translation present
   parameter bit HAS_LANDING_PAD_INSTR   = 1'b1,  // Landing pads present
   parameter bit HAS_SSTK   = 1'b1,  // Shadow stacks present
   parameter bit HAS_CBO    = 1'b0,  // Cache-block ops present
   parameter bit HAS_IBITS  = 1'b1,  // Instruction bits reported
   parameter int MAX_MAX_INSTRUCTION_LENGTH   = 32     // Max instruction length in bits
)(
   input  wire logic        ref_clk,    // Hart clock
   input  wire logic        rst_n,      // Async reset, active low
   input  wire logic        psel,       // APB select
   input  wire logic        penable,    // APB enable
   input  wire logic        pwrite,     // APB direction
   input  wire logic [11:0] paddr,      // APB byte address
   input  wire logic [31:0] pwdata,     // APB write data
   input  wire logic [3:0]  pstrb,      // APB byte strobes
   output logic [31:0]      prdata,     // APB read data
   output logic             pready,     // APB ready
   output logic             pslverr,    // APB error
   input  wire stv_trap_t   trap,       // Trap entry from trap logic
   input  wire logic        machSse,    // Machine shadow-stack enable
   output stv_ctl_t         ctl,        // Controls to pipeline
   output logic [31:0]      tval        // Current trap value
);
   // ==========================================================
   // Writable mask of the configuration register
   localparam logic [31:0] ENV_MASK =
      ({31'h0, HAS_XLATE} << STV_BIT_FIOW) |
      ({31'h0, HAS_LANDING_PAD_INSTR}  << STV_BIT_LPE)  |
      ({31'h0, HAS_SSTK}  << STV_BIT_SSE)  |
      ({28'h0, {4{HAS_CBO}}} << STV_LO_CIE);
   localparam int NBITS = (MAX_MAX_INSTRUCTION_LENGTH < 32) ? MAX_MAX_INSTRUCTION_LENGTH : 32;

   stv_state_t st;
   stv_state_t next_st;

   // Byte-lane merge, used by both registers
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  stb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (stb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Right-justify instruction bits, clearing unused upper bits
   function automatic logic [31:0] ibits(input logic [31:0] ins,
                                         input logic [5:0]  len);
      logic [31:0] r;
      int          n;
      r = 32'h0;
      n = (int'(len) < NBITS) ? int'(len) : NBITS;
      for (int i = 0; i < 32; i++) begin
         if (i < n) begin
            r[i] = ins[i];
         end
      end
      return r;
   endfunction

   logic wrEn;
   logic rdEn;
   logic mapped;
   assign wrEn   = psel && penable && pwrite;
   assign rdEn   = psel && !penable && !pwrite;
   assign mapped = (paddr == STV_OFF_TVAL) || (paddr == STV_OFF_ENVCFG) ||
                   (paddr == STV_OFF_STATUS);

   // ==========================================================
   // Next-state logic
   always_comb begin
      next_st = st;
      // Software write lands first so a same-cycle trap overrides it
      if (wrEn && paddr == STV_OFF_TVAL) begin
         next_st.tval = merge(st.tval, pwdata, pstrb);
      end
      if (wrEn && paddr == STV_OFF_ENVCFG) begin
         // Reserved bits are masked to zero; absent fields stay zero
         next_st.envcfg = merge(st.envcfg, pwdata, pstrb) & ENV_MASK;
      end
      if (wrEn && paddr == STV_OFF_STATUS) begin
         next_st.trapSeen = 1'b0;
      end
      if (trap.take) begin
         next_st.trapSeen = 1'b1;
         case (trap.kind)
            STV_TK_ADDR: next_st.tval = trap.addr;
            STV_TK_ILL:  next_st.tval = HAS_IBITS ?
                            ibits(trap.instr, trap.max_instruction_length) : 32'h0;
            STV_TK_SWC: begin
               case (trap.swc)
                  2'h2:    next_st.tval = STV_SWC_LANDING_PAD_INSTR;
                  2'h3:    next_st.tval = STV_SWC_SSTK;
                  default: next_st.tval = STV_SWC_NONE;
               endcase
            end
            default:     next_st.tval = 32'h0;
         endcase
      end
      // Read data is captured in setup, valid in the access phase
      if (rdEn) begin
         case (paddr)
            STV_OFF_TVAL:   next_st.prdata = st.tval;
            STV_OFF_ENVCFG: next_st.prdata = st.envcfg;
            STV_OFF_STATUS: next_st.prdata = {31'h0, st.trapSeen};
            default:        next_st.prdata = 32'h0;
         endcase
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '{tval: STV_TVAL_RESET, envcfg: STV_ENVCFG_RESET,
                 prdata: 32'h0, trapSeen: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   assign prdata  = st.prdata;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign tval    = st.tval;
   // Controls decoded from the configuration register; one driver for
   // the whole struct, since the machine enable is on this same clock
   assign ctl = '{
      lpActive:   st.envcfg[STV_BIT_LPE],
      ssActive:   st.envcfg[STV_BIT_SSE],
      fenceWiden: st.envcfg[STV_BIT_FIOW],
      ssSwapIll:  !st.envcfg[STV_BIT_SSE] && machSse,
      ssSwapVirt: !st.envcfg[STV_BIT_SSE] && machSse
   };

   // ==========================================================
   // Checks
   // Every property runs on the hart clock; the assertions sleep in reset, the covers do not.
   // Expected values are rebuilt from the trap entry and the bus,
   // not from next_st, so a slip in the decode cannot hide itself.

   // Address-class traps keep the address exactly as delivered
   trap_addr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_ADDR
      |=> tval == $past(trap.addr))
      else $error("trap value not faulting address");

   // A trap that meets a software write in one cycle must win
   trap_wins_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_ADDR &&
      wrEn && paddr == STV_OFF_TVAL
      |=> tval == $past(trap.addr))
      else $error("software write beat a trap");

   // Traps with no defined information leave zero behind
   trap_other_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_OTHER |=> tval == 32'h0)
      else $error("other trap did not zero value");

   // With neither a trap nor a write the value must not drift
   hold_tval_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !trap.take && !(wrEn && paddr == STV_OFF_TVAL)
      |=> $stable(tval))
      else $error("trap value changed on its own");

   // A full-word software write stores the word unchanged
   tval_write_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !trap.take && wrEn && paddr == STV_OFF_TVAL && pstrb == 4'hf
      |=> tval == $past(pwdata))
      else $error("software write not stored");

   // Byte lane 1 keeps its old byte while its strobe is low
   strb_lane_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !trap.take && wrEn && paddr == STV_OFF_TVAL && !pstrb[1]
      |=> tval[15:8] == $past(tval[15:8]))
      else $error("unstrobed byte lane written");

   // Landing-pad faults report code 2
   swc_code_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_SWC && trap.swc == 2'h2
      |=> tval == STV_SWC_LANDING_PAD_INSTR)
      else $error("wrong software-check code");

   // Shadow-stack faults report code 3
   swc_sstk_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_SWC && trap.swc == 2'h3
      |=> tval == STV_SWC_SSTK)
      else $error("wrong shadow-stack code");

   // Undefined code 1 folds into the no-information code
   swc_none_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_SWC && trap.swc[1] == 1'b0
      |=> tval == STV_SWC_NONE)
      else $error("software-check code not cleared");

   // Short instructions leave the upper half clear
   ill_upper_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_ILL && trap.max_instruction_length == 6'd16
      |=> tval[31:16] == 16'h0)
      else $error("upper instruction bits not cleared");

   // An 8-bit record keeps exactly the low byte of the bits
   ill_short_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_ILL && trap.max_instruction_length == 6'd8 &&
      HAS_IBITS && MAX_MAX_INSTRUCTION_LENGTH >= 8
      |=> tval == {24'h0, $past(trap.instr[7:0])})
      else $error("short instruction bits wrong");

   // Long instructions are cut to the register width, not wrapped
   ill_full_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take && trap.kind == STV_TK_ILL && trap.max_instruction_length >= 6'd32 &&
      HAS_IBITS && MAX_MAX_INSTRUCTION_LENGTH >= 32
      |=> tval == $past(trap.instr))
      else $error("full instruction bits wrong");

   // Absent and reserved fields never hold a one
   env_rsvd_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      (st.envcfg & ~ENV_MASK) == 32'h0)
      else $error("reserved config bit set");

   // Traps and other writes leave the configuration alone
   env_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !(wrEn && paddr == STV_OFF_ENVCFG)
      |=> $stable(st.envcfg))
      else $error("configuration changed without a write");

   // Fence widening follows bit 0, or stays off without translation
   fence_ctl_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == STV_OFF_ENVCFG && pstrb[0]
      |=> ctl.fenceWiden == ($past(pwdata[STV_BIT_FIOW]) && HAS_XLATE))
      else $error("fence widening control mismatch");

   // Landing-pad checking follows the bit software last wrote
   lp_ctl_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == STV_OFF_ENVCFG && pstrb[0]
      |=> ctl.lpActive == ($past(pwdata[STV_BIT_LPE]) && HAS_LANDING_PAD_INSTR))
      else $error("landing pad control mismatch");

   // Shadow stacks follow the bit software last wrote
   ss_ctl_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == STV_OFF_ENVCFG && pstrb[0]
      |=> ctl.ssActive == ($past(pwdata[STV_BIT_SSE]) && HAS_SSTK))
      else $error("shadow stack control mismatch");

   // The swap fault needs the machine enable and a clear user enable
   swap_ill_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      ctl.ssSwapIll |-> machSse && !ctl.ssActive)
      else $error("swap fault without cause");

   // Both fault lines must rise whenever that case holds
   swap_virt_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      machSse && !ctl.ssActive
      |-> ctl.ssSwapIll && ctl.ssSwapVirt)
      else $error("swap fault missing");

   // A trap marks the status flag even against a clearing write
   status_set_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      trap.take |=> st.trapSeen)
      else $error("trap not recorded in status");

   // A status write with no trap clears the flag
   status_clr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr == STV_OFF_STATUS && !trap.take
      |=> !st.trapSeen)
      else $error("status flag not cleared");

   // Read data is the register as it stood in the setup cycle
   read_tval_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == STV_OFF_TVAL |=> prdata == $past(tval))
      else $error("trap value read back wrong");

   // Configuration reads return the stored word
   read_env_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == STV_OFF_ENVCFG
      |=> prdata == $past(st.envcfg))
      else $error("configuration read back wrong");

   // Status reads show the sticky trap flag in bit 0 alone
   read_stat_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      rdEn && paddr == STV_OFF_STATUS
      |=> prdata == {31'h0, $past(st.trapSeen)})
      else $error("status read back wrong");

   // Read data stands until the next read setup
   prdata_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      !rdEn |=> $stable(prdata))
      else $error("read data moved outside a read");

   // No wait states: every access phase completes at once
   ready_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      psel && penable |-> pready)
      else $error("access phase stalled");

   // Addresses past the map are refused
   slverr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      psel && penable && paddr > STV_OFF_STATUS |-> pslverr)
      else $error("unmapped access not refused");

   // A refused write must not reach either register
   unmap_write_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n)
      wrEn && paddr > STV_OFF_STATUS && !trap.take
      |=> $stable(tval) && $stable(st.envcfg))
      else $error("refused write changed a register");

   // Scenarios that must be seen at least once
   cov_addr_c: cover property (@(posedge ref_clk)
      trap.take && trap.kind == STV_TK_ADDR);
   cov_ill_c: cover property (@(posedge ref_clk)
      trap.take && trap.kind == STV_TK_ILL);
   cov_swc_c: cover property (@(posedge ref_clk)
      trap.take && trap.kind == STV_TK_SWC);
   cov_envwr_c: cover property (@(posedge ref_clk)
      wrEn && paddr == STV_OFF_ENVCFG);
   // The trap and software write collision is the rare corner
   cov_clash_c: cover property (@(posedge ref_clk)
      trap.take && wrEn && paddr == STV_OFF_TVAL);
endmodule
`default_nettype wire

/* File: tb/stv_trap_model.sv */
// Purpose: Stand-in for the hart trap logic feeding trap entries.
// Assumes: The bench raises fire for one cycle for each trap.
// Notes:   Idle fields show inverted junk so stale data is never trusted.
`timescale 1ns/1ps
`default_nettype none
module stv_trap_model
   import stv_pkg::*;
(
   input  wire logic      fire,  // Issue a trap this cycle
   input  wire stv_trap_t info,  // Trap details from the bench
   output stv_trap_t      trap   // Trap entry toward the block
);
   // ==========================================================
   // Take follows fire; other fields flip while idle
   always_comb begin
      trap      = fire ? info : stv_trap_t'(~info);
      trap.take = fire;
   end
endmodule
`default_nettype wire

/* File: tb/stv_core_bench.sv */
// Purpose: Self-checking bench for the trap value and env config block.
// Assumes: Zero-wait APB slave, default design parameters.
// Notes:   Random data from a fixed-seed shift register, corners mixed in.
`timescale 1ns/1ps
`default_nettype none
module stv_core_bench
   import stv_pkg::*;
;
   logic        ref_clk, rst_n, psel, penable, pwrite, fire, machSse;
   logic        pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, tval, got, seed, v;
   logic [3:0]  pstrb;
   stv_trap_t   info, trap;
   stv_ctl_t    ctl;
   int          error_cnt, total_checks;
   logic [5:0]  lens [4] = '{6'h10, 6'h20, 6'h30, 6'h08};
   logic [1:0]  codes [3] = '{2'h0, 2'h2, 2'h3};

   stv_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trap(trap), .machSse(machSse), .ctl(ctl), .tval(tval));
   stv_trap_model far (.fire(fire), .info(info), .trap(trap));

   // ==========================================================
   // Clock, 10 ns period
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Expected trap value, worked out from the trap class
   function automatic logic [31:0] exp_tval(input stv_trap_t t);
      case (t.kind)
         STV_TK_ADDR: return t.addr;
         STV_TK_ILL:  return (t.max_instruction_length >= 6'h20) ? t.instr :
                         t.instr & ((32'h1 << t.max_instruction_length) - 32'h1);
         STV_TK_SWC:  return {30'h0, t.swc};
         default:     return 32'h0;
      endcase
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge ref_clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      got = prdata;
      e   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // One supervisor trap; address and instruction bits drawn from the shift register
   task automatic trap_go(input stv_kind_t k, input logic [5:0] l,
                          input logic [1:0] s);
      @(posedge ref_clk);
      info <= '{1'b1, k, seed, {seed[15:0], seed[31:16]}, l, s};
      fire <= 1'b1;
      seed = lfsr(seed);
      @(posedge ref_clk);
      fire <= 1'b0;
      @(negedge ref_clk);
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Watchdog: the run needs about 120 cycles, allow far more
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {rst_n, psel, penable, pwrite, fire, paddr, pwdata} = '0;
      {error_cnt, total_checks} = '0;
      info = '0;
      seed = 32'h0000_003e;
      machSse = 1'b1;
      pstrb = 4'hf;
      repeat (6) @(posedge ref_clk);
      chk(tval, STV_TVAL_RESET);
      rst_n <= 1'b1;
      apb(1'b0, STV_OFF_ENVCFG, 32'h0);
      chk(got, STV_ENVCFG_RESET);
      $display("test reset done");
      for (int n = 0; n < 6; n++) begin
         v = (n == 0) ? 32'hffff_ffff : (n == 1) ? 32'h0 : seed;
         machSse <= seed[9];
         seed = lfsr(seed);
         apb(1'b1, STV_OFF_ENVCFG, v);
         apb(1'b0, STV_OFF_ENVCFG, 32'h0);
         chk(got, v & 32'h0000_000d);
         chk({31'h0, ctl.fenceWiden}, {31'h0, v[0]});
         chk({31'h0, ctl.lpActive}, {31'h0, v[2]});
         chk({31'h0, ctl.ssActive}, {31'h0, v[3]});
         chk({31'h0, ctl.ssSwapIll}, {31'h0, machSse & ~v[3]});
         chk({31'h0, ctl.ssSwapVirt}, {31'h0, machSse & ~v[3]});
      end
      $display("test envcfg done");
      apb(1'b1, STV_OFF_TVAL, seed);
      apb(1'b0, STV_OFF_TVAL, 32'h0);
      chk(got, seed);
      // Lanes 1 and 3 are left out; look after the edge has settled
      pstrb <= 4'h5;
      apb(1'b1, STV_OFF_TVAL, ~seed);
      pstrb <= 4'hf;
      @(negedge ref_clk);
      v = ~seed;
      chk(tval, {seed[31:24], v[23:16], seed[15:8], v[7:0]});
      // Trap taken at the very edge at which a write lands
      fork
         apb(1'b1, STV_OFF_TVAL, 32'h0);
         begin
            @(posedge ref_clk);
            trap_go(STV_TK_ADDR, 6'h20, 2'h0);
         end
      join
      chk(tval, exp_tval(info));
      for (int n = 0; n < 4; n++) begin
         trap_go(STV_TK_ADDR, 6'h20, 2'h0);
         chk(tval, exp_tval(info));
         apb(1'b0, STV_OFF_TVAL, 32'h0);
         chk(got, exp_tval(info));
      end
      repeat (4) @(posedge ref_clk);
      chk(tval, exp_tval(info));
      apb(1'b0, STV_OFF_STATUS, 32'h0);
      chk(got, 32'h1);
      apb(1'b1, STV_OFF_STATUS, 32'h0);
      apb(1'b0, STV_OFF_STATUS, 32'h0);
      chk(got, 32'h0);
      foreach (lens[n]) begin
         trap_go(STV_TK_ILL, lens[n], 2'h0);
         chk(tval, exp_tval(info));
      end
      foreach (codes[n]) begin
         trap_go(STV_TK_SWC, 6'h20, codes[n]);
         chk(tval, {30'h0, codes[n]});
      end
      trap_go(STV_TK_OTHER, 6'h20, 2'h3);
      chk(tval, 32'h0);
      $display("test traps done");
      apb(1'b1, 12'h00c, 32'hffff_ffff);
      chk({31'h0, e}, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk(got, 32'h0);
      chk({31'h0, e}, 32'h1);
      $display("test unmapped done");
      conclude();
   end
endmodule
`default_nettype wire
